// ===== design/pww_consts.svh
`ifndef PWW_CONSTS_SVH
`define PWW_CONSTS_SVH

// Reset timeout, in por_timing_osc cycles
`define PWW_RESET_TIMEOUT_CYC 7'h40
// Watchdog intervals, in window_timing_osc cycles
`define PWW_ARM_DELAY_CYC 7'h21
`define PWW_WINDOW_LOWER_CYC 7'h04
`define PWW_WINDOW_UPPER_CYC 7'h40
// Counter width shared by all timing counters
`define PWW_CNT_W 7
// Number of reset channels
`define PWW_NUM_CH 2
// Channel indices
`define PWW_CH_HV 0
`define PWW_CH_LV 1
// Default oscillator periods in CLK_SYS cycles (stand in for the timing capacitors)
`define PWW_POR_OSC_DIV_DEF 16
`define PWW_WIN_OSC_DIV_DEF 16
// Divider counter width
`define PWW_DIV_W 16

`endif

// ===== design/pww_pkg.sv
package pww_pkg;

    // Watchdog sequencer states, one-hot
    typedef enum logic [3:0] {
        PWW_IDLE  = 4'b0001,
        PWW_ARM   = 4'b0010,
        PWW_WATCH = 4'b0100,
        PWW_FAULT = 4'b1000
    } pww_state_t;

endpackage

// ===== design/pww_top.sv
// Behaviour
// R1: Both power-good monitors always evaluated
// R2: Reset outputs are active-low open-drain
// R3: Shared oscillator, 64 cycles reset timeout
// R4: Either power-good starts reset oscillator
// R5: Each channel reset released independently
// R6: Watchdog runs only while enable low
// R7: Window oscillator starts once both released
// R8: Arm delay ignores kick transitions
// R9: Arm 33, lower 4, upper 64 cycles
// R10: After arm, measure falling edge spacing
// R11: Out-of-window kick pulses fault one timeout
// R12: Upper bound expiry faults without waiting
// R13: Valid kick edge restarts window count
// R14: Good kicks keep reset oscillator stopped
// R15: Fault release starts new arm delay
// R16: Fault output is active-low open-drain
// R17: Processor kicks within window bounds
// R18: Disabled watchdog clears state, fault released
// R19: Inputs pass two-stage synchroniser first
`timescale 1ns/1ps
`include "pww_consts.svh"

module pww_top
    import pww_pkg::*;
#(
    parameter int POR_OSC_DIV = `PWW_POR_OSC_DIV_DEF,
    parameter int WIN_OSC_DIV = `PWW_WIN_OSC_DIV_DEF
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic HV_FEEDBACK_GOOD,
    input wire logic LV_FEEDBACK_GOOD,
    input wire logic WATCHDOG_ENABLE_N,
    input wire logic KICK_INPUT,
    input wire logic HV_POWER_ON_RESET_N_I,
    output logic HV_POWER_ON_RESET_N_O,
    output logic HV_POWER_ON_RESET_N_OE,
    input wire logic LV_POWER_ON_RESET_N_I,
    output logic LV_POWER_ON_RESET_N_O,
    output logic LV_POWER_ON_RESET_N_OE,
    output logic WATCHDOG_FAULT_N_O,
    output logic WATCHDOG_FAULT_N_OE
);

    // Refuse oscillator periods the dividers cannot serve
    if (POR_OSC_DIV < 1 || POR_OSC_DIV > 65535) begin : g_chk_por
        $error("POR_OSC_DIV out of range");
    end
    if (WIN_OSC_DIV < 1 || WIN_OSC_DIV > 65535) begin : g_chk_win
        $error("WIN_OSC_DIV out of range");
    end

    localparam logic [`PWW_DIV_W-1:0] POR_LAST = `PWW_DIV_W'(POR_OSC_DIV - 1);
    localparam logic [`PWW_DIV_W-1:0] WIN_LAST = `PWW_DIV_W'(WIN_OSC_DIV - 1);
    localparam int NSYNC = 6;

    // Bit positions of each pin input inside the synchroniser bank
    localparam int SY_HV_GOOD = 0;
    localparam int SY_LV_GOOD = 1;
    localparam int SY_ENABLE_N = 2;
    localparam int SY_KICK = 3;
    localparam int SY_HV_PIN = 4;
    localparam int SY_LV_PIN = 5;

    // Timing model
    // The two capacitor oscillators are stood in for by dividers of CLK_SYS.
    // One divider wrap is one oscillator cycle, and every timing count in
    // this block counts those wraps, never raw system clocks.
    // A divider is held at zero while its oscillator is stopped. The first
    // cycle after a start is therefore always a full one.
    // The price is a phase error of at most one system clock per start.
    // Against a 64-cycle timeout this is far below the spread that a real
    // timing capacitor would show, so it was not worth compensating.
    // All pin inputs are asynchronous and reach the logic two clocks late.
    // Every threshold below sits on top of that fixed latency.

    // Saturating increment used by every timing counter.
    // Saturation keeps a counter parked at its limit if a tick arrives in the
    // same cycle as the state change that would clear it.
    function automatic logic [`PWW_CNT_W-1:0] sat_inc(
        input logic [`PWW_CNT_W-1:0] value,
        input logic [`PWW_CNT_W-1:0] limit
    );
        sat_inc = (value >= limit) ? limit : value + `PWW_CNT_W'(1);
    endfunction

    // Synchroniser stages; only stage two is read by logic
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    wire [NSYNC-1:0] raw_in;
    assign raw_in = {LV_POWER_ON_RESET_N_I, HV_POWER_ON_RESET_N_I, KICK_INPUT,
                     WATCHDOG_ENABLE_N, LV_FEEDBACK_GOOD, HV_FEEDBACK_GOOD};

    // Two flops per pin input, no reset so nothing but the pin feeds stage one.
    // The bank is not reset, so RESET must be held for a few clocks to flush it.
    always_ff @(posedge CLK_SYS) begin
        sync_a <= raw_in; // R19
        sync_b <= sync_a; // R19
    end

    wire [`PWW_NUM_CH-1:0] fb_good;
    wire wd_enable;
    wire kick_sync;
    wire [`PWW_NUM_CH-1:0] rst_pin_high;
    assign fb_good = {sync_b[SY_LV_GOOD], sync_b[SY_HV_GOOD]}; // R1
    assign wd_enable = ~sync_b[SY_ENABLE_N]; // R6
    assign kick_sync = sync_b[SY_KICK];
    assign rst_pin_high = {sync_b[SY_LV_PIN], sync_b[SY_HV_PIN]};

    // Kick edge detect on the synchronised copy.
    // The previous value resets high, the idle level of the pin, so leaving
    // reset never fakes a falling edge.
    logic kick_prev;
    wire kick_fall;
    assign kick_fall = kick_prev & ~kick_sync; // R10

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            kick_prev <= 1'b1;
        end else begin
            kick_prev <= kick_sync;
        end
    end

    // Sequencer state and counters
    pww_state_t state;
    pww_state_t next_state;
    logic [`PWW_CNT_W-1:0] wcnt;
    logic [`PWW_CNT_W-1:0] next_wcnt;
    logic [`PWW_CNT_W-1:0] fcnt;
    logic [`PWW_CNT_W-1:0] next_fcnt;
    logic have_edge;
    logic next_have_edge;

    // One-hot state decodes, shared by the oscillator gates
    wire in_arm;
    wire in_watch;
    wire in_fault;
    assign in_arm = (state == PWW_ARM);
    assign in_watch = (state == PWW_WATCH);
    assign in_fault = (state == PWW_FAULT);

    logic [`PWW_NUM_CH-1:0] rst_released;
    wire both_released;
    // Wired-OR pins: another device holding a reset low also holds off the watchdog
    assign both_released = &rst_released & &rst_pin_high; // R7

    // Reset oscillator runs while any channel is still sequencing, or during a fault.
    // Once both resets are out it stops, so steady good kicks leave it idle.
    wire por_run;
    assign por_run = ((|fb_good) & ~both_released) | in_fault; // R4 R14

    // Window oscillator runs only while arming or watching
    wire win_run;
    assign win_run = in_arm | in_watch; // R7

    // Too-close kick: a second edge before the lower bound has passed
    wire next_fault_from_kick;
    assign next_fault_from_kick = have_edge & (wcnt < `PWW_WINDOW_LOWER_CYC); // R11

    // Oscillator stand-ins: dividers restart from zero whenever stopped
    logic [`PWW_DIV_W-1:0] por_div;
    logic [`PWW_DIV_W-1:0] win_div;
    wire por_tick;
    wire win_tick;
    wire win_restart;
    assign por_tick = por_run & (por_div == POR_LAST); // R3
    assign win_tick = win_run & (win_div == WIN_LAST) & ~win_restart;
    // A valid kick resets the window oscillator phase as well as the count, so the
    // next interval is measured from the edge and not from a stale divider phase
    assign win_restart = in_watch & kick_fall & ~next_fault_from_kick;

    always_ff @(posedge CLK_SYS) begin
        if (RESET || !por_run || por_tick) begin
            por_div <= '0;
        end else begin
            por_div <= por_div + `PWW_DIV_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET || !win_run || win_restart || win_tick) begin
            win_div <= '0; // R13
        end else begin
            win_div <= win_div + `PWW_DIV_W'(1);
        end
    end

    // Per-channel reset timers on the shared oscillator.
    // Both channels count the same ticks, so a channel that comes good later
    // simply starts counting later; it does not restart the other one.
    // The done flag is registered twice before it reaches the pin, in rst_released
    // and in the output register, which keeps the release glitch-free and two clocks behind the count.
    logic [`PWW_CNT_W-1:0] rcnt [`PWW_NUM_CH];
    genvar ch;
    for (ch = 0; ch < `PWW_NUM_CH; ch++) begin : g_ch
        wire done;
        assign done = (rcnt[ch] == `PWW_RESET_TIMEOUT_CYC); // R3

        // Power-good loss restarts this channel's timeout only
        always_ff @(posedge CLK_SYS) begin
            if (RESET || !fb_good[ch]) begin
                rcnt[ch] <= '0;
                rst_released[ch] <= 1'b0;
            end else begin
                if (por_tick && !done) begin
                    rcnt[ch] <= sat_inc(rcnt[ch], `PWW_RESET_TIMEOUT_CYC);
                end
                rst_released[ch] <= done; // R5
            end
        end
    end

    // Watchdog sequencer, next-state logic.
    // IDLE waits for enable and both resets out; ARM ignores the kick pin;
    // WATCH measures edge spacing; FAULT holds the fault pin for one timeout.
    // The first edge in WATCH only opens an interval, since nothing before
    // it can be trusted after the arm delay. The upper bound is timed from
    // the end of arming, so a processor that never kicks is still caught.
    // Disable, or any reset pin pulled low, overrides every state below.
    always_comb begin
        next_state = state;
        next_wcnt = wcnt;
        next_fcnt = fcnt;
        next_have_edge = have_edge;
        unique case (state)
            PWW_IDLE: begin
                next_wcnt = '0;
                next_fcnt = '0;
                next_have_edge = 1'b0;
                if (wd_enable && both_released) begin
                    next_state = PWW_ARM; // R7
                end
            end
            PWW_ARM: begin
                // Kick edges are not looked at here
                if (win_tick) begin
                    next_wcnt = sat_inc(wcnt, `PWW_ARM_DELAY_CYC); // R8
                end
                if (next_wcnt == `PWW_ARM_DELAY_CYC) begin
                    next_state = PWW_WATCH; // R9
                    next_wcnt = '0;
                    next_have_edge = 1'b0;
                end
            end
            PWW_WATCH: begin
                if (kick_fall) begin
                    if (next_fault_from_kick) begin
                        next_state = PWW_FAULT; // R11
                        next_fcnt = '0;
                    end else begin
                        next_wcnt = '0; // R13
                        next_have_edge = 1'b1;
                    end
                end else if (win_tick) begin
                    next_wcnt = sat_inc(wcnt, `PWW_WINDOW_UPPER_CYC);
                    if (next_wcnt == `PWW_WINDOW_UPPER_CYC) begin
                        next_state = PWW_FAULT; // R12
                        next_fcnt = '0;
                    end
                end
            end
            PWW_FAULT: begin
                if (por_tick) begin
                    next_fcnt = sat_inc(fcnt, `PWW_RESET_TIMEOUT_CYC);
                end
                if (next_fcnt == `PWW_RESET_TIMEOUT_CYC) begin
                    next_state = PWW_ARM; // R15
                    next_wcnt = '0;
                    next_fcnt = '0;
                    next_have_edge = 1'b0;
                end
            end
        endcase
        // Disable or a reset reasserting drops everything back to idle
        if (!wd_enable || !both_released) begin
            next_state = PWW_IDLE; // R18
            next_wcnt = '0;
            next_fcnt = '0;
            next_have_edge = 1'b0;
        end
    end

    // Sequencer registers; RESET returns everything to idle
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state <= PWW_IDLE;
            wcnt <= '0;
            fcnt <= '0;
            have_edge <= 1'b0;
        end else begin
            state <= next_state;
            wcnt <= next_wcnt;
            fcnt <= next_fcnt;
            have_edge <= next_have_edge;
        end
    end

    // Open-drain pins: data held low, enable pulls the line down.
    // The fault enable is taken from the next state so that the pin moves on
    // the same edge as the sequencer, without an extra clock of lag.
    // Pull-ups are outside this block; a released pin is high only through them.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            HV_POWER_ON_RESET_N_O <= 1'b0;
            LV_POWER_ON_RESET_N_O <= 1'b0;
            WATCHDOG_FAULT_N_O <= 1'b0;
            HV_POWER_ON_RESET_N_OE <= 1'b1;
            LV_POWER_ON_RESET_N_OE <= 1'b1;
            WATCHDOG_FAULT_N_OE <= 1'b0;
        end else begin
            HV_POWER_ON_RESET_N_O <= 1'b0;
            LV_POWER_ON_RESET_N_O <= 1'b0;
            WATCHDOG_FAULT_N_O <= 1'b0;
            HV_POWER_ON_RESET_N_OE <= ~rst_released[`PWW_CH_HV]; // R2
            LV_POWER_ON_RESET_N_OE <= ~rst_released[`PWW_CH_LV]; // R2
            WATCHDOG_FAULT_N_OE <= (next_state == PWW_FAULT); // R16 R11
        end
    end

endmodule

// ===== testbench/pww_chk.sv
`timescale 1ns/1ps
module pww_chk #(
    parameter int POR_OSC_DIV = 16,
    parameter int WIN_OSC_DIV = 16
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic HV_FEEDBACK_GOOD,
    input wire logic WATCHDOG_ENABLE_N,
    input wire logic KICK_INPUT,
    input wire logic HV_POWER_ON_RESET_N_I,
    input wire logic LV_POWER_ON_RESET_N_I,
    input logic HV_POWER_ON_RESET_N_OE,
    input logic WATCHDOG_FAULT_N_OE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    int hv_n, flt_n, q_n, k_n, en_n;
    // Margins of a few clocks cover synchroniser delay and divider phase
    wire logic steady = !WATCHDOG_ENABLE_N && HV_POWER_ON_RESET_N_I && LV_POWER_ON_RESET_N_I;
    // Run lengths that the timing checks are measured against
    always_ff @(posedge CLK_SYS) begin
        hv_n <= (RESET || !HV_FEEDBACK_GOOD) ? 0 : hv_n + 1;
        flt_n <= (RESET || !WATCHDOG_FAULT_N_OE) ? 0 : flt_n + 1;
        q_n <= (RESET || !steady || WATCHDOG_FAULT_N_OE) ? 0 : q_n + 1;
        en_n <= (RESET || !steady) ? 0 : en_n + 1;
        k_n <= (RESET || $fell(KICK_INPUT)) ? 0 : k_n + 1;
    end
    hv_early_a: assert property ($fell(HV_POWER_ON_RESET_N_OE) |-> hv_n >= 63*POR_OSC_DIV)
        else $error("hv reset released early");
    hv_late_a: assert property (hv_n > 65*POR_OSC_DIV+8 |-> !HV_POWER_ON_RESET_N_OE)
        else $error("hv reset released late");
    hv_loss_a: assert property ($fell(HV_FEEDBACK_GOOD) |-> ##[1:4] HV_POWER_ON_RESET_N_OE)
        else $error("hv reset not reasserted");
    wd_off_a: assert property (WATCHDOG_ENABLE_N [*5] |-> !WATCHDOG_FAULT_N_OE)
        else $error("fault while disabled");
    pin_low_a: assert property (!HV_POWER_ON_RESET_N_I [*5] |-> !WATCHDOG_FAULT_N_OE)
        else $error("fault while reset pin low");
    arm_first_a: assert property ($rose(WATCHDOG_FAULT_N_OE) |-> q_n >= 33*WIN_OSC_DIV)
        else $error("fault inside arm delay");
    fault_len_a: assert property ($fell(WATCHDOG_FAULT_N_OE) && en_n > 8 |->
        flt_n >= 63*POR_OSC_DIV)
        else $error("fault pulse short");
    fault_max_a: assert property (WATCHDOG_FAULT_N_OE |-> flt_n <= 65*POR_OSC_DIV+4)
        else $error("fault pulse long");
    upper_exp_a: assert property (q_n > 100*WIN_OSC_DIV+8 |-> k_n <= 66*WIN_OSC_DIV+8)
        else $error("upper bound expiry missed");
    cover property ($rose(WATCHDOG_FAULT_N_OE));
    cover property ($fell(HV_POWER_ON_RESET_N_OE));
    cover property ($fell(WATCHDOG_FAULT_N_OE) && en_n > 8);
endmodule
bind pww_top pww_chk #(.POR_OSC_DIV(POR_OSC_DIV), .WIN_OSC_DIV(WIN_OSC_DIV)) pww_chk_i (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .HV_FEEDBACK_GOOD(HV_FEEDBACK_GOOD),
    .WATCHDOG_ENABLE_N(WATCHDOG_ENABLE_N), .KICK_INPUT(KICK_INPUT),
    .HV_POWER_ON_RESET_N_I(HV_POWER_ON_RESET_N_I), .LV_POWER_ON_RESET_N_I(LV_POWER_ON_RESET_N_I),
    .HV_POWER_ON_RESET_N_OE(HV_POWER_ON_RESET_N_OE), .WATCHDOG_FAULT_N_OE(WATCHDOG_FAULT_N_OE));

// ===== testbench/pww_kick_model.sv
`timescale 1ns/1ps
module pww_kick_model (
    input wire logic clk,
    input wire logic [7:0] period,
    output logic kick
);
    logic [7:0] cnt = 8'h00;
    initial kick = 1'b1;
    // Two-clock low pulse per period so the synchroniser sees it; zero period stops
    always @(posedge clk) begin
        #1;
        cnt = (period == 8'h00 || cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
        kick = !(period != 8'h00 && cnt < 8'h02);
    end
endmodule

// ===== testbench/tb_por_window_watchdog.sv
`timescale 1ns/1ps
module tb_por_window_watchdog;
    localparam int DIV = 2;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hv_good = 1'b0;
    logic lv_good = 1'b0;
    logic en_n = 1'b1;
    logic [7:0] period = 8'h00;
    logic kick, hv_o, hv_oe, lv_o, lv_oe, wf_o, wf_oe;
    int fail_count = 0;
    int comparisons = 0;
    int t;
    // Weak pull-ups on the reset pins
    wire logic hv_pin = !hv_oe;
    wire logic lv_pin = !lv_oe;
    always #4 clk_sys = !clk_sys;
    pww_top #(.POR_OSC_DIV(DIV), .WIN_OSC_DIV(DIV)) pww_top_i (
        .CLK_SYS(clk_sys), .RESET(reset), .HV_FEEDBACK_GOOD(hv_good),
        .LV_FEEDBACK_GOOD(lv_good), .WATCHDOG_ENABLE_N(en_n), .KICK_INPUT(kick),
        .HV_POWER_ON_RESET_N_I(hv_pin), .HV_POWER_ON_RESET_N_O(hv_o),
        .HV_POWER_ON_RESET_N_OE(hv_oe), .LV_POWER_ON_RESET_N_I(lv_pin),
        .LV_POWER_ON_RESET_N_O(lv_o), .LV_POWER_ON_RESET_N_OE(lv_oe),
        .WATCHDOG_FAULT_N_O(wf_o), .WATCHDOG_FAULT_N_OE(wf_oe));
    pww_kick_model pww_kick_model_i (.clk(clk_sys), .period(period), .kick(kick));
    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %0b seen %0b", what, exp, seen);
        end
    endtask
    // Inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? hv_oe : (w == 1 ? lv_oe : wf_oe);
    endfunction
    // Bounded wait; the elapsed clocks are left in t
    task automatic wait_oe(input int w, input logic v, input int lim);
        t = 0;
        while (pick(w) !== v) begin
            step(1);
            t++;
            if (t > lim) begin
                check("wait done", 1'b0, 1'b1);
                wrap_up();
            end
        end
    endtask
    task automatic por_seq();
        hv_good = 1'b1;
        wait_oe(0, 1'b0, 200);
        check("hv release time", t >= 63*DIV, 1'b1);
        check("lv held", lv_oe, 1'b1);
        lv_good = 1'b1;
        wait_oe(1, 1'b0, 66*DIV+8);
        hv_good = 1'b0;
        step(5);
        check("hv reasserted", hv_oe, 1'b1);
        check("lv independent", lv_oe, 1'b0);
        hv_good = 1'b1;
        wait_oe(0, 1'b0, 200);
    endtask
    task automatic good_kicks();
        period = 8'h28;
        en_n = 1'b0;
        t = 0;
        repeat (1500) begin
            step(1);
            t += int'(wf_oe !== 1'b0);
        end
        check("no fault on good kicks", t == 0, 1'b1);
    endtask
    task automatic slow_kicks();
        period = 8'h00;
        wait_oe(2, 1'b1, 66*DIV+12);
        wait_oe(2, 1'b0, 66*DIV+8);
        check("fault length", t >= 63*DIV, 1'b1);
        step(33*DIV-4);
        check("rearmed quietly", wf_oe, 1'b0);
    endtask
    task automatic fast_kicks();
        period = 8'h04;
        wait_oe(2, 1'b1, 40*DIV);
        wait_oe(2, 1'b0, 66*DIV+8);
        wait_oe(2, 1'b1, 40*DIV);
        check("arm ignores kicks", t >= 33*DIV, 1'b1);
    endtask
    task automatic disable_wd();
        en_n = 1'b1;
        step(5);
        check("fault cleared", wf_oe, 1'b0);
        check("drain data low", wf_o | hv_o | lv_o, 1'b0);
        en_n = 1'b0;
        wait_oe(2, 1'b1, 40*DIV);
        check("rearm on enable", t >= 33*DIV, 1'b1);
    endtask
    initial begin
        step(10);
        reset = 1'b0;
        por_seq();
        good_kicks();
        slow_kicks();
        fast_kicks();
        disable_wd();
        wrap_up();
    end
endmodule
